/* src/rtcaf_pkg.sv */
// Purpose: Constants and carrier types for the alarm and flag block
// Assumes: 40 MHz system clock, byte-wide register port
// Notes: Offsets are byte addresses on the parallel bus
package rtcaf_pkg;
    localparam logic [4:0] ADDR_MONTH = 5'h05;
    localparam logic [4:0] ADDR_AL_SEC = 5'h08;
    localparam logic [4:0] ADDR_AL_MIN = 5'h09;
    localparam logic [4:0] ADDR_AL_HOUR = 5'h0A;
    localparam logic [4:0] ADDR_AL_DD = 5'h0B;
    localparam logic [4:0] ADDR_FLAGS = 5'h0E;
    localparam logic [4:0] ADDR_CTRL = 5'h0F;
    // Month byte fields
    localparam int MON_OSC_STOP = 7;
    localparam int MON_CLK_DIS = 6;
    localparam int MON_BKP_CLK = 5;
    // Alarm byte fields
    localparam int AL_MASK = 7;
    localparam int AL_WEEKDAY = 6;
    localparam logic [7:0] AL_SEC_VAL = 8'h7F;
    localparam logic [7:0] AL_HOUR_VAL = 8'h3F;
    localparam logic [7:0] AL_DD_VAL = 8'h3F;
    // Flag byte fields
    localparam int FL_MAIN_LOW = 7;
    localparam int FL_AUX_LOW = 6;
    localparam int FL_FAILHOLD = 5;
    localparam int FL_FLOAT = 4;
    localparam int FL_ALARM = 3;
    localparam int FL_KICK = 2;
    localparam int FL_WD = 1;
    localparam int FL_IRQ = 0;
    // Control byte fields
    localparam int CT_TE = 7;
    localparam int CT_ALARM_PWR = 4;
    localparam int CT_ALARM_IRQ = 3;
    localparam int CT_KICK_IRQ = 2;
    localparam int CT_WD_EN = 1;
    // Reset values
    localparam logic [7:0] MONTH_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h80;
    localparam logic [7:0] AL_RST = 8'h80;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    // Address must be stable this long while selected
    localparam int ADDR_STABLE_NS = 15;
    localparam int CLK_PERIOD_NS = 25;
    localparam int STABLE_CYC_I =
        (ADDR_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] STABLE_CYC =
        (STABLE_CYC_I < 1) ? 2'h1 : STABLE_CYC_I[1:0];

    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] date;
        logic [7:0] day;
    } rtcaf_time_t;

    typedef struct packed {
        logic [7:0] month_r;
        logic [7:0] al_sec_r;
        logic [7:0] al_min_r;
        logic [7:0] al_hour_r;
        logic [7:0] al_dd_r;
        logic [7:0] ctrl_r;
        logic failhold_r;
        logic float_r;
        logic alarm_r;
        logic kick_r;
        logic wd_r;
        logic rd_qual_r;
        logic [1:0] stab_cnt_r;
        logic [4:0] addr_q_r;
        logic sel_q_r;
        logic [7:0] rdata_r;
        logic tick_q_r;
    } rtcaf_state_t;
endpackage

/* src/rtcaf_alarm_flags.sv */
// Purpose: Alarm match, control and status flags of a backed-up clock
// Assumes: Bus strobes and battery levels are synchronous to i_clk
// Notes: Time counters, watchdog and kickstart detection are outside
//        Alarm needs the oscillator running and transfers enabled
//        Power and interrupt pins are open drain: their _oe output high pulls the pin low
`timescale 1ns/100ps
module rtcaf_alarm_flags (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [4:0] i_addr,
    input wire logic i_cs_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_rdata_oe,
    input wire rtcaf_pkg::rtcaf_time_t i_time,
    input wire logic i_sec_tick,
    input wire logic i_osc_clk,
    input wire logic i_main_batt_low,
    input wire logic i_aux_batt_low,
    input wire logic i_aux_battery_supply,
    input wire logic i_backup_mode,
    input wire logic i_power_fail,
    input wire logic i_kick_event,
    input wire logic i_wd_timeout,
    output logic o_osc_stop_n,
    output logic o_clk32_out,
    output logic o_clk32_oe,
    output logic o_power_on_out_n,
    output logic o_power_on_oe,
    output logic o_irq_n,
    output logic o_irq_oe
);
    rtcaf_pkg::rtcaf_state_t st_r;
    rtcaf_pkg::rtcaf_state_t st_nxt;

    logic sel;
    logic wr_en;
    logic match;
    logic tick;
    logic irq;
    logic [3:0] masks;
    logic sec_eq;
    logic min_eq;
    logic hour_eq;
    logic dd_eq;
    logic [7:0] dd_cur;
    logic [7:0] flags_rd;
    logic rd_clear;
    logic wr_flags;
    logic alarm_set;
    logic alarm_irq;
    logic kick_irq;
    logic wd_irq;
    logic [7:0] rd_mux;
    logic clk_backup_ok;
    logic pwr_hold;
    logic alarm_nxt;
    logic kick_nxt;
    logic wd_nxt;

    typedef enum logic [2:0] {
        MODE_EVERY_SEC = 3'h0,
        MODE_SEC = 3'h1,
        MODE_MIN_SEC = 3'h2,
        MODE_HMS = 3'h3,
        MODE_DAY_HMS = 3'h4
    } rtcaf_mode_t;
    rtcaf_mode_t mode;

    ////////////////////////////////////////////////////////////////////////
    // Alarm comparison
    always_comb begin
        masks = {st_r.al_dd_r[rtcaf_pkg::AL_MASK],
                 st_r.al_hour_r[rtcaf_pkg::AL_MASK],
                 st_r.al_min_r[rtcaf_pkg::AL_MASK],
                 st_r.al_sec_r[rtcaf_pkg::AL_MASK]};
        dd_cur = st_r.al_dd_r[rtcaf_pkg::AL_WEEKDAY] ? i_time.day
                                                     : i_time.date;
        unique case (masks)
            4'hF: mode = MODE_EVERY_SEC;
            4'hE: mode = MODE_SEC;
            4'hC: mode = MODE_MIN_SEC;
            4'h8: mode = MODE_HMS;
            4'h0: mode = MODE_DAY_HMS;
            default: mode = MODE_EVERY_SEC;
        endcase
        unique case (mode)
            MODE_EVERY_SEC: match = 1'b1;
            MODE_SEC: match = sec_eq;
            MODE_MIN_SEC: match = sec_eq & min_eq;
            MODE_HMS: match = sec_eq & min_eq & hour_eq;
            MODE_DAY_HMS: match = sec_eq & min_eq & hour_eq & dd_eq;
            default: match = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Value fields only: mask and weekday select bits never compare
    rtcaf_field_eq #(
        .VAL_MASK(rtcaf_pkg::AL_SEC_VAL)
    ) i_rtcaf_field_eq_sec (
        .i_alarm(st_r.al_sec_r),
        .i_count(i_time.sec),
        .o_equal(sec_eq)
    );

    rtcaf_field_eq #(
        .VAL_MASK(rtcaf_pkg::AL_SEC_VAL)
    ) i_rtcaf_field_eq_min (
        .i_alarm(st_r.al_min_r),
        .i_count(i_time.min),
        .o_equal(min_eq)
    );

    rtcaf_field_eq #(
        .VAL_MASK(rtcaf_pkg::AL_HOUR_VAL)
    ) i_rtcaf_field_eq_hour (
        .i_alarm(st_r.al_hour_r),
        .i_count(i_time.hour),
        .o_equal(hour_eq)
    );

    rtcaf_field_eq #(
        .VAL_MASK(rtcaf_pkg::AL_DD_VAL)
    ) i_rtcaf_field_eq_dd (
        .i_alarm(st_r.al_dd_r),
        .i_count(dd_cur),
        .o_equal(dd_eq)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    assign sel = !i_cs_n;
    assign wr_en = sel && !i_we_n;
    assign tick = i_sec_tick && !st_r.tick_q_r;
    // Compare on each new second, only when transfers run
    assign alarm_set = tick && match &&
                       st_r.ctrl_r[rtcaf_pkg::CT_TE] &&
                       !st_r.month_r[rtcaf_pkg::MON_OSC_STOP];
    assign wr_flags = wr_en && (i_addr == rtcaf_pkg::ADDR_FLAGS);
    // Qualified read ends on address change or strobe release
    assign rd_clear = st_r.rd_qual_r &&
                      (i_cs_n || i_oe_n ||
                       (i_addr != st_r.addr_q_r));

    assign alarm_irq = st_r.alarm_r && st_r.ctrl_r[rtcaf_pkg::CT_ALARM_IRQ];
    assign kick_irq = st_r.kick_r && st_r.ctrl_r[rtcaf_pkg::CT_KICK_IRQ];
    assign wd_irq = st_r.wd_r && st_r.ctrl_r[rtcaf_pkg::CT_WD_EN];
    assign irq = alarm_irq || kick_irq || wd_irq;

    always_comb begin
        flags_rd = 8'h00;
        flags_rd[rtcaf_pkg::FL_MAIN_LOW] = i_main_batt_low;
        flags_rd[rtcaf_pkg::FL_AUX_LOW] = i_aux_batt_low;
        flags_rd[rtcaf_pkg::FL_FAILHOLD] = st_r.failhold_r;
        flags_rd[rtcaf_pkg::FL_FLOAT] = st_r.float_r;
        flags_rd[rtcaf_pkg::FL_ALARM] = st_r.alarm_r;
        flags_rd[rtcaf_pkg::FL_KICK] = st_r.kick_r;
        flags_rd[rtcaf_pkg::FL_WD] = st_r.wd_r;
        flags_rd[rtcaf_pkg::FL_IRQ] = irq;
    end

    // Byte selected for the read port
    always_comb begin
        unique case (i_addr)
            rtcaf_pkg::ADDR_MONTH: rd_mux = st_r.month_r;
            rtcaf_pkg::ADDR_AL_SEC: rd_mux = st_r.al_sec_r;
            rtcaf_pkg::ADDR_AL_MIN: rd_mux = st_r.al_min_r;
            rtcaf_pkg::ADDR_AL_HOUR: rd_mux = st_r.al_hour_r;
            rtcaf_pkg::ADDR_AL_DD: rd_mux = st_r.al_dd_r;
            rtcaf_pkg::ADDR_CTRL: rd_mux = st_r.ctrl_r;
            rtcaf_pkg::ADDR_FLAGS: rd_mux = flags_rd;
            default: rd_mux = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags: a hardware set wins over a read or write clear
    rtcaf_flag_nxt i_rtcaf_flag_nxt_alarm (
        .i_flag(st_r.alarm_r),
        .i_set(alarm_set),
        .i_load(wr_flags && !i_wdata[rtcaf_pkg::FL_ALARM]),
        .i_load_val(1'b0),
        .i_clear(rd_clear),
        .o_flag(alarm_nxt)
    );

    rtcaf_flag_nxt i_rtcaf_flag_nxt_kick (
        .i_flag(st_r.kick_r),
        .i_set(i_kick_event),
        .i_load(wr_flags),
        .i_load_val(i_wdata[rtcaf_pkg::FL_KICK]),
        .i_clear(rd_clear),
        .o_flag(kick_nxt)
    );

    rtcaf_flag_nxt i_rtcaf_flag_nxt_wd (
        .i_flag(st_r.wd_r),
        .i_set(i_wd_timeout),
        .i_load(wr_flags && !i_wdata[rtcaf_pkg::FL_WD]),
        .i_load_val(1'b0),
        .i_clear(rd_clear),
        .o_flag(wd_nxt)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick_q_r = i_sec_tick;
        st_nxt.addr_q_r = i_addr;
        st_nxt.sel_q_r = sel && !i_oe_n;
        // Address stability timer during a flag read
        if (sel && !i_oe_n && i_we_n && i_addr == rtcaf_pkg::ADDR_FLAGS &&
            i_addr == st_r.addr_q_r && st_r.sel_q_r) begin
            if (st_r.stab_cnt_r != rtcaf_pkg::STABLE_CYC) begin
                st_nxt.stab_cnt_r = st_r.stab_cnt_r + 2'h1;
            end else begin
                st_nxt.rd_qual_r = 1'b1;
            end
        end else begin
            st_nxt.stab_cnt_r = 2'h0;
        end
        if (rd_clear) begin
            st_nxt.rd_qual_r = 1'b0;
            st_nxt.stab_cnt_r = 2'h0;
        end
        // Register writes
        if (wr_en) begin
            unique case (i_addr)
                rtcaf_pkg::ADDR_MONTH: st_nxt.month_r = i_wdata;
                rtcaf_pkg::ADDR_AL_SEC: st_nxt.al_sec_r = i_wdata;
                rtcaf_pkg::ADDR_AL_MIN: st_nxt.al_min_r = i_wdata;
                rtcaf_pkg::ADDR_AL_HOUR: st_nxt.al_hour_r = i_wdata;
                rtcaf_pkg::ADDR_AL_DD: st_nxt.al_dd_r = i_wdata;
                rtcaf_pkg::ADDR_CTRL: st_nxt.ctrl_r = i_wdata;
                rtcaf_pkg::ADDR_FLAGS: begin
                    st_nxt.failhold_r = i_wdata[rtcaf_pkg::FL_FAILHOLD];
                    st_nxt.float_r = i_wdata[rtcaf_pkg::FL_FLOAT];
                end
                default: begin
                end
            endcase
        end
        // Flags come from the set-wins cells
        st_nxt.alarm_r = alarm_nxt;
        st_nxt.kick_r = kick_nxt;
        st_nxt.wd_r = wd_nxt;
        if ((st_nxt.alarm_r && st_nxt.ctrl_r[rtcaf_pkg::CT_ALARM_PWR]) ||
            st_nxt.kick_r) begin
            st_nxt.float_r = 1'b0;
        end
        // Read data
        if (sel && !i_oe_n && i_we_n) begin
            st_nxt.rdata_r = rd_mux;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_r <= '0;
            st_r.month_r <= rtcaf_pkg::MONTH_RST;
            st_r.ctrl_r <= rtcaf_pkg::CTRL_RST;
            st_r.al_sec_r <= rtcaf_pkg::AL_RST;
            st_r.al_min_r <= rtcaf_pkg::AL_RST;
            st_r.al_hour_r <= rtcaf_pkg::AL_RST;
            st_r.al_dd_r <= rtcaf_pkg::AL_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins
    logic clk_run;
    logic pwr_drive;
    assign clk_run = !st_r.month_r[rtcaf_pkg::MON_OSC_STOP] &&
                     !st_r.month_r[rtcaf_pkg::MON_CLK_DIS];
    assign o_osc_stop_n = st_r.month_r[rtcaf_pkg::MON_OSC_STOP];
    assign o_clk32_out = i_osc_clk;
    assign clk_backup_ok = st_r.month_r[rtcaf_pkg::MON_BKP_CLK] &&
                           i_aux_battery_supply;
    assign o_clk32_oe = clk_run && (!i_backup_mode || clk_backup_ok);
    assign pwr_drive = !st_r.float_r;
    assign o_power_on_out_n = 1'b0;
    // Power fail releases the pin unless failhold keeps it
    assign pwr_hold = !i_power_fail || st_r.failhold_r;
    assign o_power_on_oe = pwr_drive && pwr_hold;
    assign o_irq_n = 1'b0;
    assign o_irq_oe = irq;
    assign o_rdata = st_r.rdata_r;
    assign o_rdata_oe = sel && !i_oe_n && i_we_n;
endmodule

////////////////////////////////////////////////////////////////////////////
// Equality of the value bits of one alarm byte and one counter byte
module rtcaf_field_eq #(
    parameter logic [7:0] VAL_MASK = 8'hFF
) (
    input wire logic [7:0] i_alarm,
    input wire logic [7:0] i_count,
    output logic o_equal
);
    assign o_equal = (i_alarm & VAL_MASK) == (i_count & VAL_MASK);
endmodule

////////////////////////////////////////////////////////////////////////////
// Next value of one sticky flag: set beats load, load beats clear
module rtcaf_flag_nxt (
    input wire logic i_flag,
    input wire logic i_set,
    input wire logic i_load,
    input wire logic i_load_val,
    input wire logic i_clear,
    output logic o_flag
);
    always_comb begin
        o_flag = i_flag;
        if (i_clear) begin
            o_flag = 1'b0;
        end
        if (i_load) begin
            o_flag = i_load_val;
        end
        if (i_set) begin
            o_flag = 1'b1;
        end
    end
endmodule

/* tb/rtcaf_alarm_flags_properties.sv */
// Purpose: Port properties of the alarm and flag block
// Assumes: One clock domain, synchronous active-high reset
// Notes: Internal flags are seen only through pins and read data
`timescale 1ns/100ps
module rtcaf_alarm_flags_properties (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [4:0] i_addr,
    input wire logic i_cs_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic o_rdata_oe,
    input wire logic i_osc_clk,
    input wire logic i_main_batt_low,
    input wire logic i_aux_batt_low,
    input wire logic i_power_fail,
    input wire logic i_kick_event,
    input wire logic o_osc_stop_n,
    input wire logic o_clk32_out,
    input wire logic o_power_on_out_n,
    input wire logic o_power_on_oe,
    input wire logic o_irq_n,
    input wire logic o_irq_oe
);
    logic rd_fl;
    logic wr_mon;
    assign rd_fl = !i_cs_n && !i_oe_n && i_we_n && i_addr == 5'h0E;
    assign wr_mon = !i_cs_n && !i_we_n && i_addr == 5'h05;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    ////////////////////////////////////////////////////////////////////
    a_clk_pass: assert property (o_clk32_out == i_osc_clk)
        else $error("square-wave output differs from oscillator");
    a_irq_low: assert property (o_irq_n == 1'b0)
        else $error("interrupt pin does not drive low");
    a_pwr_low: assert property (o_power_on_out_n == 1'b0)
        else $error("power pin does not drive low");
    a_osc_write: assert property (
        wr_mon |=> o_osc_stop_n == $past(i_wdata[7]))
        else $error("oscillator stop does not follow month write");
    a_batt_read: assert property (
        rd_fl ##1 rd_fl |->
        o_rdata[7:6] == $past({i_main_batt_low, i_aux_batt_low}))
        else $error("battery bits wrong in flag read");
    a_read_drive: assert property (
        o_rdata_oe == (!i_cs_n && !i_oe_n && i_we_n))
        else $error("read data enable wrong");
    a_flag_clear: assert property (
        rd_fl [*5] ##1 i_oe_n |-> ##[1:2] !o_irq_oe)
        else $error("interrupt not cleared after flag read");
    a_kick_wake: assert property (
        i_kick_event && !i_power_fail |-> ##[1:3] o_power_on_oe)
        else $error("kick event did not activate power pin");
    c_flag_read: cover property (rd_fl [*5] ##1 i_oe_n);
    c_kick: cover property (i_kick_event);
    c_month_wr: cover property (wr_mon);
endmodule
bind rtcaf_alarm_flags rtcaf_alarm_flags_properties
    i_rtcaf_alarm_flags_properties (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_cs_n(i_cs_n), .i_oe_n(i_oe_n), .i_we_n(i_we_n),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rdata_oe(o_rdata_oe),
    .i_osc_clk(i_osc_clk), .i_main_batt_low(i_main_batt_low),
    .i_aux_batt_low(i_aux_batt_low), .i_power_fail(i_power_fail),
    .i_kick_event(i_kick_event), .o_osc_stop_n(o_osc_stop_n),
    .o_clk32_out(o_clk32_out), .o_power_on_out_n(o_power_on_out_n),
    .o_power_on_oe(o_power_on_oe), .o_irq_n(o_irq_n), .o_irq_oe(o_irq_oe)
);

/* tb/rtcaf_host_bfm.sv */
// Purpose: Host processor model on the byte-wide strobe bus
// Assumes: Strobes change only on falling clock edges
// Notes: Reads hold address and strobes five cycles to qualify
`timescale 1ns/100ps
module rtcaf_host_bfm (
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    output logic [4:0] o_addr,
    output logic o_cs_n,
    output logic o_oe_n,
    output logic o_we_n,
    output logic [7:0] o_wdata
);
    initial {o_addr, o_wdata, o_cs_n, o_oe_n, o_we_n} = 16'h0007;
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_addr = a;
        o_wdata = d;
        {o_cs_n, o_we_n} = 2'h0;
        @(negedge i_clk);
        {o_cs_n, o_we_n} = 2'h3;
        // Released data lines show the inverse, not the last byte
        o_wdata = ~d;
        @(negedge i_clk);
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(negedge i_clk);
        o_addr = a;
        {o_cs_n, o_oe_n} = 2'h0;
        repeat (5) @(negedge i_clk);
        d = i_rdata;
        {o_cs_n, o_oe_n} = 2'h3;
        @(negedge i_clk);
    endtask
endmodule

/* tb/tb.sv */
// Purpose: Self-checking bench for the alarm and flag block
// Assumes: Host model drives the register bus on falling edges
// Notes: Alarm cases come from one table of bytes and expectations
`timescale 1ns/100ps
module tb;
    localparam logic [4:0] FL = 5'h0E;
    localparam logic [4:0] CT = 5'h0F;
    // Address and expected reset byte
    localparam logic [12:0] RST_TBL [8] = '{13'h0500, 13'h0880,
        13'h0980, 13'h0A80, 13'h0B80, 13'h0E00, 13'h0F80, 13'h1F00};
    // Month byte, backup mode, aux supply, expected clock enable
    localparam logic [19:0] MON_TBL [5] = '{20'h00011, 20'h80010,
        20'h40010, 20'h20111, 20'h20100};
    // Expected flag, control, alarm sec, min, hour, day/date
    localparam logic [43:0] AL_TBL [13] = '{44'h1_88_80_80_80_80,
        44'h1_88_30_80_80_80, 44'h0_88_31_80_80_80, 44'h1_88_30_15_80_80,
        44'h0_88_30_16_80_80, 44'h1_88_30_15_08_80, 44'h0_88_30_15_09_80,
        44'h1_88_30_15_08_21, 44'h0_88_30_15_08_03, 44'h1_88_30_15_08_43,
        44'h0_88_30_15_08_61, 44'h1_88_B1_16_80_80, 44'h0_08_80_80_80_80};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic osc = 1'b0;
    logic [4:0] addr;
    logic cs_n, oe_n, we_n, tick, mlow, alow, aux, bkp, pfail, kick, wdt;
    logic c32_oe, pwr_oe, irq_oe, e;
    logic [7:0] wdata, rdata, fx;
    rtcaf_pkg::rtcaf_time_t tv;
    int miscompares = 0;
    int n_checks = 0;
    always #12.5 clk = ~clk;
    always #1000 osc = ~osc;
    rtcaf_host_bfm i_rtcaf_host_bfm (.i_clk(clk), .i_rdata(rdata),
        .o_addr(addr), .o_cs_n(cs_n), .o_oe_n(oe_n), .o_we_n(we_n),
        .o_wdata(wdata));
    rtcaf_alarm_flags i_rtcaf_alarm_flags (
        .i_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_cs_n(cs_n),
        .i_oe_n(oe_n), .i_we_n(we_n), .i_wdata(wdata), .o_rdata(rdata),
        .o_rdata_oe(), .i_time(tv), .i_sec_tick(tick), .i_osc_clk(osc),
        .i_main_batt_low(mlow), .i_aux_batt_low(alow),
        .i_aux_battery_supply(aux), .i_backup_mode(bkp),
        .i_power_fail(pfail), .i_kick_event(kick), .i_wd_timeout(wdt),
        .o_osc_stop_n(), .o_clk32_out(), .o_clk32_oe(c32_oe),
        .o_power_on_out_n(), .o_power_on_oe(pwr_oe), .o_irq_n(),
        .o_irq_oe(irq_oe));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic chk1(input logic seen, input logic exp);
        chk({7'h00, seen}, {7'h00, exp});
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        i_rtcaf_host_bfm.wr(a, v);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [7:0] x);
        logic [7:0] v;
        i_rtcaf_host_bfm.rd(a, v);
        chk(v, x);
    endtask
    // Index 0 pulses the second tick, 1 the kick, 2 the watchdog
    task automatic pulse(input int w);
        @(negedge clk);
        {wdt, kick, tick} = 3'h1 << w;
        @(negedge clk);
        {wdt, kick, tick} = 3'h0;
        repeat (2) @(negedge clk);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        {tick, mlow, alow, bkp, pfail, kick, wdt} = 7'h00;
        aux = 1'b1;
        tv = {8'h30, 8'h15, 8'h08, 8'h21, 8'h03};
        repeat (16) @(negedge clk);
        rst = 1'b0;
        foreach (RST_TBL[k]) begin
            rdc(RST_TBL[k][12:8], RST_TBL[k][7:0]);
        end
        foreach (MON_TBL[k]) begin
            wr(5'h05, MON_TBL[k][19:12]);
            bkp = MON_TBL[k][8];
            aux = MON_TBL[k][4];
            @(negedge clk);
            chk1(c32_oe, MON_TBL[k][0]);
        end
        {bkp, aux} = 2'h1;
        for (int k = 1; k < 4; k++) begin
            {mlow, alow} = k[1:0];
            rdc(FL, {k[1:0], 6'h00});
        end
        {mlow, alow} = 2'h0;
        $display("test registers done");
        foreach (AL_TBL[k]) begin
            wr(CT, AL_TBL[k][39:32]);
            for (int j = 0; j < 4; j++) begin
                wr(5'h08 + j[4:0], AL_TBL[k][31 - 8 * j -: 8]);
            end
            pulse(0);
            e = AL_TBL[k][40];
            fx = {4'h0, e, 2'h0, e};
            chk1(irq_oe, e);
            rdc(FL, fx);
            chk1(irq_oe, 1'b0);
        end
        $display("test alarm done");
        wr(CT, 8'h90);
        wr(FL, 8'h10);
        chk1(pwr_oe, 1'b0);
        pulse(0);
        chk1(pwr_oe, 1'b1);
        rdc(FL, 8'h08);
        wr(CT, 8'h84);
        wr(FL, 8'h04);
        chk1(irq_oe, 1'b1);
        wr(FL, 8'h10);
        chk1(irq_oe, 1'b0);
        pulse(1);
        chk1(pwr_oe, 1'b1);
        rdc(FL, 8'h05);
        wr(CT, 8'h82);
        pulse(2);
        chk1(irq_oe, 1'b1);
        wr(FL, 8'h00);
        chk1(irq_oe, 1'b0);
        wr(FL, 8'h20);
        pfail = 1'b1;
        @(negedge clk);
        chk1(pwr_oe, 1'b1);
        wr(FL, 8'h00);
        chk1(pwr_oe, 1'b0);
        $display("test power pin done");
        end_of_test();
    end
endmodule
